/* File: sls_top.sv */
/*
  Source-address learn analysis and storm policing step of a switch
  analyzer, with an AXI4-Lite register slave. Earlier analyzer steps
  present a frame's decision and source lookup result for one cycle;
  the adjusted decision leaves two cycles later for the queue system.
*/
// Notes on behaviour
// - Learn-disabled frames skip all learning
// - Search one table domain, backbone or customer
// - Normal learn: miss or unlocked moved, under limit
// - Same but over limit: over-limit learn frame
// - Locked entry with other index: locked move
// - Learn needs enable, no disable, not policed
// - Learning off ignores all learn port settings
// - Auto-learn inserts entry into searched domain
// - Drop-learn clears destinations of normal frames
// - Copy-learn adds CPU port and learn queue
// - Over-limit discard clears destinations
// - Over-limit copy adds CPU and learn queue
// - Locked-move discard clears destinations
// - Locked-move copy adds CPU and move queue
// - Hit: block flag clears, copy flag queues
// - Global control skips source entry flags
// - Four storm policers shared by all ports
// - Several policers may act; any over polices
// - Broadcast, multicast, unicast floods; learn copies
// - Unit one or kilo, rate times power two
// - Action clears queues, destinations or both
// - Port group with CPU still reaches CPU
`timescale 1ns/100ps
module sls_top #(
  parameter int PW = 12,
  parameter int QW = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [sls_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sls_pkg::DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [sls_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sls_pkg::DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Frame decision from earlier steps
  input wire logic in_valid,
  input wire logic [$clog2(PW)-1:0] physical_ingress_port,
  input wire logic [$clog2(PW)-1:0] logical_ingress_port,
  input wire logic [47:0] port_set_a_mac,
  input wire logic flooded,
  input wire logic port_group_entry_cpu,
  input wire logic [PW-1:0] port_set_a_in,
  input wire logic [QW-1:0] cpu_queue_set_in,
  input wire logic learn_disable_flag,
  input wire logic ingress_policed,
  input wire logic search_backbone,
  // Source lookup result
  input wire logic src_hit,
  input wire logic src_locked,
  input wire logic [$clog2(PW)-1:0] entry_port_set_a_index,
  input wire logic source_block_flag,
  input wire logic entry_copy_flag,
  input wire logic learn_entry_limit_hit,
  // Adjusted decision to the queue system
  output logic out_valid,
  output logic [PW-1:0] port_set_a_out,
  output logic [QW-1:0] cpu_queue_set_out,
  // Table insert request
  output logic learn_insert,
  output logic learn_backbone,
  output logic [$clog2(PW)-1:0] learn_logical_ingress_port
);
  import sls_pkg::*;

  localparam int PIW = $clog2(PW);
  localparam int CPU = PW - 1;

  // Byte-lane merge of a write into a register word
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
      input logic [DW-1:0] data, input logic [3:0] strb);
    logic [DW-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = data[8*b +: 8];
    end
    return r;
  endfunction : merge

  // One-hot queue bit from a queue number
  function automatic logic [QW-1:0] qbit(input logic [QS_W-1:0] n);
    return QW'(1) << n;
  endfunction : qbit

  // Register bus state
  logic aw_got_reg, w_got_reg, rd_pend_reg, rd_wait_reg;
  logic [AW-1:0] awaddr_reg, araddr_reg;
  logic [DW-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire, wr_port, rd_port, wr_ok, rd_ok;
  logic [PC_W-1:0] pcfg_rd, pcfg_frame;
  logic [DW-1:0] rd_word;

  // Software registers
  logic gen_ctrl_reg;
  logic [DW-1:0] queue_sel_reg;
  logic [DW-1:0] learn_cnt_reg;
  logic [7:0] lim_cfg_reg [NLIM];
  logic [BURST_W-1:0] lim_burst_reg [NLIM];
  logic [BURST_W-1:0] lim_level [NLIM];
  logic [NLIM-1:0] lim_over, lim_hit;

  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign wr_port = awaddr_reg[7] && (awaddr_reg[6:2] < 5'(PW));
  assign rd_port = araddr_reg[7] && (araddr_reg[6:2] < 5'(PW));

  // Address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_reg <= 1'b0;
      end
    end
  end

  // Ready raised every other cycle while the matching holder is free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_reg && !s_axi_awready
        && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_got_reg && !s_axi_wready
        && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Write decode: mapped offsets except the limiter levels answer OKAY, others SLVERR
  always_comb begin
    wr_ok = wr_port || awaddr_reg == OFS_GEN_CTRL
      || awaddr_reg == OFS_QUEUE_SEL || awaddr_reg == OFS_LEARN_CNT
      || (awaddr_reg[7:5] == 3'h0 && awaddr_reg[4])
      || (awaddr_reg[7:4] == 4'h2);
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_ctrl_reg <= 1'b0;
      queue_sel_reg <= QS_RESET;
      for (int i = 0; i < NLIM; i++) begin
        lim_cfg_reg[i] <= LC_RESET;
        lim_burst_reg[i] <= BURST_RESET;
      end
    end else if (wr_fire) begin
      if (awaddr_reg == OFS_GEN_CTRL && wstrb_reg[0])
        gen_ctrl_reg <= wdata_reg[0];
      if (awaddr_reg == OFS_QUEUE_SEL)
        queue_sel_reg <= merge(queue_sel_reg, wdata_reg, wstrb_reg);
      for (int i = 0; i < NLIM; i++) begin
        if (awaddr_reg == OFS_LIM_CFG + 8'(4*i) && wstrb_reg[0])
          lim_cfg_reg[i] <= wdata_reg[7:0];
        if (awaddr_reg == OFS_LIM_BURST + 8'(4*i))
          lim_burst_reg[i] <= BURST_W'(merge(DW'(lim_burst_reg[i]),
            wdata_reg, wstrb_reg));
      end
    end
  end

  // Per-port learn settings
  sls_cfg_mem #(.W(PC_W), .D(PW)) u_port_cfg (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(wr_fire && wr_port && wstrb_reg[0]),
    .waddr(awaddr_reg[PIW+1:2]),
    .wdata(wdata_reg[PC_W-1:0]),
    .raddr_a(physical_ingress_port),
    .rdata_a(pcfg_frame),
    .raddr_b(araddr_reg[PIW+1:2]),
    .rdata_b(pcfg_rd)
  );

  // Read: address taken, memory read, then data registered out
  always_comb begin
    rd_ok = 1'b1;
    rd_word = '0;
    if (rd_port) rd_word = DW'(pcfg_rd);
    else if (araddr_reg == OFS_GEN_CTRL) rd_word = DW'(gen_ctrl_reg);
    else if (araddr_reg == OFS_QUEUE_SEL) rd_word = queue_sel_reg;
    else if (araddr_reg == OFS_LEARN_CNT) rd_word = learn_cnt_reg;
    else if (araddr_reg[7:4] == 4'h1)
      rd_word = DW'(lim_cfg_reg[araddr_reg[3:2]]);
    else if (araddr_reg[7:4] == 4'h2)
      rd_word = DW'(lim_burst_reg[araddr_reg[3:2]]);
    else if (araddr_reg[7:4] == 4'h3)
      rd_word = DW'(lim_level[araddr_reg[3:2]]);
    else rd_ok = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      rd_wait_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      araddr_reg <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !rd_wait_reg && !rd_pend_reg
        && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_reg <= s_axi_araddr;
        rd_wait_reg <= 1'b1;
      end
      // Port memory output follows the held address one cycle later
      if (rd_wait_reg) begin
        rd_wait_reg <= 1'b0;
        rd_pend_reg <= 1'b1;
      end
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Frame held for the cycle in which its port settings are read
  logic s1_valid_reg, s1_dis_reg, s1_pol_reg, s1_bb_reg, s1_flood_reg;
  logic s1_pgcpu_reg, s1_hit_reg, s1_lock_reg, s1_blk_reg, s1_cpy_reg;
  logic s1_lim_reg;
  logic [PIW-1:0] s1_logical_ingress_port_reg, s1_idx_reg;
  logic [47:0] s1_dmac_reg;
  logic [PW-1:0] s1_port_set_a_reg;
  logic [QW-1:0] s1_cpu_queue_set_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_valid_reg <= 1'b0;
    end else begin
      s1_valid_reg <= in_valid;
    end
  end

  always_ff @(posedge aclk) begin
    if (in_valid) begin
      s1_dis_reg <= learn_disable_flag;
      s1_pol_reg <= ingress_policed;
      s1_bb_reg <= search_backbone;
      s1_flood_reg <= flooded;
      s1_pgcpu_reg <= port_group_entry_cpu;
      s1_hit_reg <= src_hit;
      s1_lock_reg <= src_locked;
      s1_blk_reg <= source_block_flag;
      s1_cpy_reg <= entry_copy_flag;
      s1_lim_reg <= learn_entry_limit_hit;
      s1_logical_ingress_port_reg <= logical_ingress_port;
      s1_idx_reg <= entry_port_set_a_index;
      s1_dmac_reg <= port_set_a_mac;
      s1_port_set_a_reg <= port_set_a_in;
      s1_cpu_queue_set_reg <= cpu_queue_set_in;
    end
  end

  // Learn classification and source-entry adjustments
  logic learn_on, moved, normal, over_lim, lock_move, to_cpu, bcast, mcast;
  logic ins_next, police;
  logic [PW-1:0] port_set_a_l, port_set_a_next;
  logic [QW-1:0] cpu_queue_set_l, cpu_queue_set_next;

  always_comb begin
    moved = s1_idx_reg != s1_logical_ingress_port_reg;
    learn_on = pcfg_frame[PC_PORT_LEARNING_ENABLE] && !s1_dis_reg
      && !s1_pol_reg;
    normal = (!s1_hit_reg || (!s1_lock_reg && moved))
      && !s1_lim_reg;
    over_lim = (!s1_hit_reg || (!s1_lock_reg && moved))
      && s1_lim_reg;
    lock_move = s1_hit_reg && s1_lock_reg && moved;
    port_set_a_l = s1_port_set_a_reg;
    cpu_queue_set_l = s1_cpu_queue_set_reg;
    to_cpu = 1'b0;
    ins_next = learn_on && normal && pcfg_frame[PC_AUTO];
    if (learn_on && normal && pcfg_frame[PC_DROP]) port_set_a_l = '0;
    if (learn_on && over_lim && pcfg_frame[PC_LIM_DROP])
      port_set_a_l = '0;
    if (learn_on && lock_move && pcfg_frame[PC_LOCK_DROP])
      port_set_a_l = '0;
    if (learn_on && ((normal && pcfg_frame[PC_CPU])
        || (over_lim && pcfg_frame[PC_LIM_CPU]))) begin
      to_cpu = 1'b1;
      port_set_a_l[CPU] = 1'b1;
      cpu_queue_set_l = cpu_queue_set_l | qbit(queue_sel_reg[QS_LEARN +: QS_W]);
    end
    if (learn_on && lock_move && pcfg_frame[PC_LOCK_CPU]) begin
      to_cpu = 1'b1;
      port_set_a_l[CPU] = 1'b1;
      cpu_queue_set_l = cpu_queue_set_l | qbit(queue_sel_reg[QS_LOCKED +: QS_W]);
    end
    if (s1_hit_reg && !gen_ctrl_reg) begin
      if (s1_blk_reg) port_set_a_l = '0;
      if (s1_cpy_reg)
        cpu_queue_set_l = cpu_queue_set_l | qbit(queue_sel_reg[QS_COPY +: QS_W]);
    end
    // Limiter classes
    bcast = &s1_dmac_reg;
    mcast = s1_dmac_reg[MCAST_BIT] && !bcast;
    lim_hit[LIM_BCAST] = s1_valid_reg && s1_flood_reg && bcast;
    lim_hit[LIM_MCAST] = s1_valid_reg && s1_flood_reg && mcast;
    lim_hit[LIM_UCAST] = s1_valid_reg && s1_flood_reg
      && !s1_dmac_reg[MCAST_BIT];
    lim_hit[LIM_LEARN] = s1_valid_reg && to_cpu;
    // Each active, over-rate limiter applies its own action
    port_set_a_next = port_set_a_l;
    cpu_queue_set_next = cpu_queue_set_l;
    police = 1'b0;
    for (int i = 0; i < NLIM; i++) begin
      if (lim_hit[i] && lim_over[i]) begin
        police = 1'b1;
        case (sls_mode_t'(lim_cfg_reg[i][LC_MODE +: 2]))
          SLS_CLR_CPU_QUEUE_SET: cpu_queue_set_next = '0;
          SLS_CLR_PORT_SET_A: port_set_a_next = '0;
          default: begin
            cpu_queue_set_next = '0;
            port_set_a_next = '0;
          end
        endcase
      end
    end
    if (police && s1_pgcpu_reg) begin
      port_set_a_next[CPU] = 1'b1;
      cpu_queue_set_next = cpu_queue_set_l;
    end
  end

  // Four limiters shared by every port
  genvar g;
  generate
    for (g = 0; g < NLIM; g++) begin : g_lim
      sls_storm_bucket u_bucket (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(lim_cfg_reg[g][LC_ENA]),
        .kilo(lim_cfg_reg[g][LC_KILO]),
        .rate_exp(lim_cfg_reg[g][LC_RATE +: 4]),
        .burst(lim_burst_reg[g]),
        .hit(lim_hit[g]),
        .over(lim_over[g]),
        .level(lim_level[g])
      );
    end
  endgenerate

  // Decision and insert request to the queue system and table
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      port_set_a_out <= '0;
      cpu_queue_set_out <= '0;
      learn_insert <= 1'b0;
      learn_backbone <= 1'b0;
      learn_logical_ingress_port <= '0;
      learn_cnt_reg <= '0;
    end else begin
      out_valid <= s1_valid_reg;
      port_set_a_out <= s1_valid_reg ? port_set_a_next : '0;
      cpu_queue_set_out <= s1_valid_reg ? cpu_queue_set_next : '0;
      learn_insert <= s1_valid_reg && ins_next;
      // Domain and port follow the last frame, zero until the first
      if (s1_valid_reg) begin
        learn_backbone <= s1_bb_reg;
        learn_logical_ingress_port <= s1_logical_ingress_port_reg;
      end
      if (s1_valid_reg && ins_next) learn_cnt_reg <= learn_cnt_reg + 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_no_learn_when_disabled;
    s1_valid_reg && s1_dis_reg |=> !learn_insert;
  endproperty
  a_no_learn_when_disabled:
    assert property (p_no_learn_when_disabled)
    else $error("insert despite learn disable");

  property p_insert_domain;
    in_valid ##1 (learn_on && normal && pcfg_frame[PC_AUTO])
      |=> learn_insert && learn_backbone == $past(search_backbone, 2);
  endproperty
  a_insert_domain: assert property (p_insert_domain)
    else $error("insert missing or wrong domain");

  property p_off_no_insert;
    s1_valid_reg && !pcfg_frame[PC_PORT_LEARNING_ENABLE] |=> !learn_insert;
  endproperty
  a_off_no_insert: assert property (p_off_no_insert)
    else $error("insert with port learning off");

  property p_drop_normal;
    s1_valid_reg && learn_on && normal && pcfg_frame[PC_DROP]
      && !pcfg_frame[PC_CPU] && !(police && s1_pgcpu_reg)
      |=> port_set_a_out == '0;
  endproperty
  a_drop_normal: assert property (p_drop_normal)
    else $error("dropped learn frame still forwarded");

  property p_copy_learn;
    s1_valid_reg && learn_on && normal && pcfg_frame[PC_CPU] && !police
      && !(s1_hit_reg && s1_blk_reg && !gen_ctrl_reg)
      |=> port_set_a_out[CPU]
      && cpu_queue_set_out[$past(queue_sel_reg[QS_LEARN +: QS_W])];
  endproperty
  a_copy_learn: assert property (p_copy_learn)
    else $error("learn copy to cpu missing");

  property p_lock_copy;
    s1_valid_reg && learn_on && lock_move && pcfg_frame[PC_LOCK_CPU]
      && !police && !(s1_blk_reg && !gen_ctrl_reg)
      |=> cpu_queue_set_out[$past(queue_sel_reg[QS_LOCKED +: QS_W])];
  endproperty
  a_lock_copy: assert property (p_lock_copy)
    else $error("locked move queue missing");

  property p_src_block;
    s1_valid_reg && s1_hit_reg && s1_blk_reg && !gen_ctrl_reg
      && !(police && s1_pgcpu_reg) |=> port_set_a_out == '0;
  endproperty
  a_src_block: assert property (p_src_block)
    else $error("blocked source still forwarded");

  property p_port_group_entry_cpu;
    s1_valid_reg && police && s1_pgcpu_reg |=> port_set_a_out[CPU];
  endproperty
  a_port_group_entry_cpu: assert property (p_port_group_entry_cpu)
    else $error("cpu port group lost to policing");

  property p_out_timing;
    in_valid |-> ##2 out_valid;
  endproperty
  a_out_timing: assert property (p_out_timing)
    else $error("decision not two cycles after input");

  c_learn: cover property (learn_insert);
  c_police: cover property (s1_valid_reg && police);
  c_lock: cover property (s1_valid_reg && learn_on && lock_move);

endmodule : sls_top

/* File: sls_pkg.sv */
/*
  Constants for the source-address learn and storm policing step:
  register offsets, field positions, reset values and timing figures.
  Assumes a 25 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package sls_pkg;

  // Bus geometry
  localparam int AW = 8;
  localparam int DW = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_GEN_CTRL = 8'h00;
  localparam logic [7:0] OFS_QUEUE_SEL = 8'h04;
  localparam logic [7:0] OFS_LEARN_CNT = 8'h08;
  localparam logic [7:0] OFS_LIM_CFG = 8'h10;
  localparam logic [7:0] OFS_LIM_BURST = 8'h20;
  localparam logic [7:0] OFS_LIM_LEVEL = 8'h30;
  localparam logic [7:0] OFS_PORT_CFG = 8'h80;

  // Per-port learn configuration fields
  localparam int PC_W = 8;
  localparam int PC_PORT_LEARNING_ENABLE = 0;
  localparam int PC_AUTO = 1;
  localparam int PC_CPU = 2;
  localparam int PC_DROP = 3;
  localparam int PC_LIM_CPU = 4;
  localparam int PC_LIM_DROP = 5;
  localparam int PC_LOCK_CPU = 6;
  localparam int PC_LOCK_DROP = 7;
  localparam logic [PC_W-1:0] PC_RESET = 8'h00;

  // Queue select fields, each a queue number
  localparam int QS_W = 3;
  localparam int QS_LEARN = 0;
  localparam int QS_LOCKED = 4;
  localparam int QS_COPY = 8;
  localparam logic [31:0] QS_RESET = 32'h0000_0000;

  // Storm limiter configuration fields
  localparam int NLIM = 4;
  localparam int LIM_BCAST = 0;
  localparam int LIM_MCAST = 1;
  localparam int LIM_UCAST = 2;
  localparam int LIM_LEARN = 3;
  localparam int LC_ENA = 0;
  localparam int LC_KILO = 1;
  localparam int LC_RATE = 2;
  localparam int LC_MODE = 6;
  localparam logic [7:0] LC_RESET = 8'h00;
  localparam int BURST_W = 16;
  localparam logic [BURST_W-1:0] BURST_RESET = 16'h0010;
  localparam logic [3:0] RATE_MAX = 4'ha;

  // Limiter actions
  typedef enum logic [1:0] {
    SLS_CLR_CPU_QUEUE_SET,
    SLS_CLR_PORT_SET_A,
    SLS_CLR_BOTH,
    SLS_CLR_BOTH2
  } sls_mode_t;

  // Destination address group bit and timing
  localparam int MCAST_BIT = 40;
  localparam int CLK_HZ = 25000000;
  localparam int KILO = 1000;
  localparam int ACC_W = 26;

endpackage : sls_pkg

/* File: sls_cfg_mem.sv */
/*
  Small per-port configuration memory, one write port and two
  registered read ports. Assumes a single clock and synchronous reset.
*/
`timescale 1ns/100ps
module sls_cfg_mem #(
  parameter int W = 8,
  parameter int D = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write port
  input wire logic we,
  input wire logic [$clog2(D)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read ports
  input wire logic [$clog2(D)-1:0] raddr_a,
  output logic [W-1:0] rdata_a,
  input wire logic [$clog2(D)-1:0] raddr_b,
  output logic [W-1:0] rdata_b
);
  import sls_pkg::*;

  logic [W-1:0] mem_reg [D];

  // Storage, cleared at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < D; i++) begin
        mem_reg[i] <= W'(PC_RESET);
      end
    end else if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  // Registered reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem_reg[raddr_a];
      rdata_b <= mem_reg[raddr_b];
    end
  end

endmodule : sls_cfg_mem

/* File: sls_storm_bucket.sv */
/*
  One frame-count storm bucket. Drains at the configured frame rate
  and flags over-rate when the level reaches the burst size.
  Assumes hit pulses for one cycle per candidate frame.
*/
`timescale 1ns/100ps
module sls_storm_bucket (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire logic enable,
  input wire logic kilo,
  input wire logic [3:0] rate_exp,
  input wire logic [sls_pkg::BURST_W-1:0] burst,
  // Candidate frame and state
  input wire logic hit,
  output logic over,
  output logic [sls_pkg::BURST_W-1:0] level
);
  import sls_pkg::*;

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] fps;
  logic [ACC_W-1:0] sum;
  logic drain;
  logic [3:0] exp_c;

  // Rate in frames per second, exponent held to the top step
  always_comb begin
    exp_c = (rate_exp > RATE_MAX) ? RATE_MAX : rate_exp;
    fps = (kilo ? ACC_W'(KILO) : ACC_W'(1)) << exp_c;
    sum = acc_reg + fps;
    drain = (sum >= ACC_W'(CLK_HZ));
  end

  // Over-rate when the bucket is full
  assign over = enable && (level >= burst);

  // Fractional drain accumulator
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      acc_reg <= '0;
    end else if (drain) begin
      acc_reg <= sum - ACC_W'(CLK_HZ);
    end else begin
      acc_reg <= sum;
    end
  end

  // Level: one per passed frame, minus drain, bounded by burst
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      level <= '0;
    end else if (hit && !over) begin
      level <= drain ? level : level + 1'b1;
    end else if (drain && level != '0) begin
      level <= level - 1'b1;
    end
  end

endmodule : sls_storm_bucket

/* File: sls_qsink.sv */
/* Queue system stand-in: keeps the last decision and counts frames.
   Assumes out_valid pulses for one cycle per frame. */
`timescale 1ns/100ps
module sls_qsink (
  // Clock
  input wire logic aclk,
  // Decision from the analyzer step
  input wire logic out_valid,
  input wire logic [11:0] ports,
  input wire logic [7:0] queues,
  input wire logic ins,
  // Last decision taken and frame count
  output logic [11:0] got_ports,
  output logic [7:0] got_queues,
  output logic got_ins,
  output int n_frames = 0
);
  // Take the decision only in the cycle it stands
  always @(posedge aclk) begin
    if (out_valid === 1'b1) begin
      got_ports <= ports;
      got_queues <= queues;
      got_ins <= ins;
      n_frames <= n_frames + 1;
    end
  end
endmodule : sls_qsink

/* File: testbench.sv */
/* Random and corner tests of the learn and storm step.
   Assumes the register map and two-cycle latency of the design. */
`timescale 1ns/100ps
module testbench;
  import sls_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1;
  logic arvalid = 0, rready = 1, in_valid = 0, fl = 0, pge = 0, ld = 0;
  logic pol = 0, bb = 0, hit = 0, lk = 0, sb = 0, cf = 0, lim = 0;
  logic awready, wready, bvalid, arready, rvalid, ov, ins, lbb, gi, skip;
  logic [7:0] awaddr = 0, araddr = 0, qin = 0, qout, gq;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] pp = 0, lp = 0, edi = 0, llp;
  logic [47:0] dmac = 0;
  logic [11:0] din = 0, dout, gd;
  logic [7:0] pc [12];
  logic [10:0] qsel;
  int fails = 0, n_tests = 0, n_fr, nf = 0, ni = 0;
  always #20 aclk = ~aclk;
  sls_top u_sls_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_valid(in_valid),
    .physical_ingress_port(pp), .logical_ingress_port(lp), .port_set_a_mac(dmac),
    .flooded(fl), .port_group_entry_cpu(pge), .port_set_a_in(din),
    .cpu_queue_set_in(qin), .learn_disable_flag(ld), .ingress_policed(pol),
    .search_backbone(bb), .src_hit(hit), .src_locked(lk),
    .entry_port_set_a_index(edi), .source_block_flag(sb), .entry_copy_flag(cf),
    .learn_entry_limit_hit(lim), .out_valid(ov), .port_set_a_out(dout),
    .cpu_queue_set_out(qout), .learn_insert(ins), .learn_backbone(lbb),
    .learn_logical_ingress_port(llp));
  sls_qsink u_sls_qsink (.aclk(aclk), .out_valid(ov), .ports(dout),
    .queues(qout), .ins(ins), .got_ports(gd), .got_queues(gq),
    .got_ins(gi), .n_frames(n_fr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ap = 1, wp = 1;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    while (ap | wp) begin
      @(posedge aclk);
      if (ap && awready) begin ap = 0; awvalid <= 0; end
      if (wp && wready) begin wp = 0; wvalid <= 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk(bresp, 0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    araddr <= a; arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, e);
    chk(rresp, (a == 8'h7c) ? 2 : 0);
  endtask : rd
  // Expected insert, queue set and port set from the learn rules
  function automatic logic [20:0] exp_out(input logic storm);
    logic on, mv, nl, i;
    logic [11:0] d;
    logic [7:0] q, c;
    c = pc[pp]; d = din; q = qin; i = 0;
    on = c[0] & !ld & !pol;
    mv = edi != lp;
    nl = !hit | (!lk & mv);
    if (on & nl & !lim) begin
      i = c[1]; if (c[3]) d = 0;
      if (c[2]) begin d[11] = 1; q[qsel[2:0]] = 1; end
    end
    if (on & nl & lim) begin
      if (c[5]) d = 0;
      if (c[4]) begin d[11] = 1; q[qsel[2:0]] = 1; end
    end
    if (on & hit & lk & mv) begin
      if (c[7]) d = 0;
      if (c[6]) begin d[11] = 1; q[qsel[6:4]] = 1; end
    end
    if (hit & !skip) begin
      if (sb) d = 0;
      if (cf) q[qsel[10:8]] = 1;
    end
    if (storm) d = 0;
    return {i, q, d};
  endfunction : exp_out
  task automatic frame(input logic storm);
    logic [20:0] e;
    in_valid <= 1; @(posedge aclk); e = exp_out(storm); in_valid <= 0; nf++;
    repeat (3) @(posedge aclk);
    ni += e[20];
    chk(gi, e[20]);
    chk(gq, e[19:12]);
    chk(gd, e[11:0]);
    chk(lbb, bb);
    chk(llp, lp);
  endtask : frame
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin #400000; fails++; complete_run; end
  initial begin
    void'($urandom(32'hfd2f));
    repeat (4) @(posedge aclk);
    aresetn <= 1; @(posedge aclk);
    rd(8'h24, 16); rd(8'h7c, 0); $display("test 1 done");
    for (int r = 0; r < 2; r++) begin
      skip = r[0]; qsel = 11'($urandom) & 11'h777;
      wr(8'h00, {31'h0, skip}); wr(8'h04, {21'h0, qsel});
      for (int p = 0; p < 12; p++) begin
        pc[p] = 8'($urandom); wr(8'(8'h80 + 4 * p), {24'h0, pc[p]});
      end
      repeat (150) begin
        pp <= 4'($urandom_range(11)); lp <= 4'($urandom); edi <= 4'($urandom);
        {ld, pol, bb, hit, lk, sb, cf, lim, pge} <= 9'($urandom);
        din <= 12'($urandom); qin <= 8'($urandom); dmac <= {$urandom, 16'h0};
        frame(0);
      end
      $display("test %0d done", r + 2);
    end
    // Broadcast limiter, burst of one frame, clearing ports when over
    wr(8'h20, 1); wr(8'h10, 8'h41); rd(8'h10, 8'h41);
    {fl, pge, hit} <= 3'b100; dmac <= '1;
    frame(0); frame(1);
    chk(n_fr, nf);
    rd(8'h80, pc[0]);
    rd(8'h08, ni);
    $display("test 4 done");
    complete_run;
  end
endmodule : testbench
